// ### common/mrls_defines.svh
// Constants for the multiple-register load/store unit.
// Assumes 32-bit words and byte addressing.
`ifndef MRLS_DEFINES_SVH
`define MRLS_DEFINES_SVH
`define MRLS_WORD_BYTES   32'h0000_0004
`define MRLS_LIT_MAX_OFS  10'h3fc
`define MRLS_REG_SP       4'hd
`define MRLS_REG_LINK     4'he
`define MRLS_REG_PC       4'hf
`define MRLS_LOW_REGS     4'h8
`define MRLS_LIST_W       9
`define MRLS_EXTRA_BIT    8
`endif

// ### common/mrls_pkg.sv
// Types for the multiple-register load/store unit.
// Assumes the defines header is compiled alongside.
package mrls_pkg;
   typedef enum logic [2:0] {
      MRLS_OP_LIT            = 3'h0,
      MRLS_OP_LOAD_MULTIPLE  = 3'h1,
      MRLS_OP_STORE_MULTIPLE = 3'h2,
      MRLS_OP_PUSH           = 3'h3,
      MRLS_OP_POP            = 3'h4
   } mrls_op_e;
   typedef enum logic [1:0] {
      MRLS_IDLE = 2'h0,
      MRLS_XFER = 2'h1,
      MRLS_WAIT = 2'h2,
      MRLS_DONE = 2'h3
   } mrls_state_e;
endpackage : mrls_pkg

// ### verilog/mrls_pick.sv
// Lowest-set-bit picker for the transfer register list.
// Pure combinational; used by the sequencing unit.
`timescale 1ns/10ps
`default_nettype none
module mrls_pick #(
   parameter int W = 9
) (
   // List in
   input  wire logic [W-1:0] list,
   // Choice out
   output logic      [3:0]   idx,
   output logic              any
);
   always_comb begin
      idx = 4'h0;
      any = 1'b0;
      for (int i = W - 1; i >= 0; i--) begin
         if (list[i]) begin
            idx = 4'(i);
            any = 1'b1;
         end
      end
   end
endmodule : mrls_pick
`default_nettype wire

// ### verilog/mrls_unit.sv
// Sequences literal, multiple and stack transfers against a word memory port.
// Assumes register file reads are combinational and memory answers with mem_ack.
`timescale 1ns/10ps
`default_nettype none
`include "mrls_defines.svh"
module mrls_unit
   import mrls_pkg::*;
#(
   parameter int LIST_W = `MRLS_LIST_W
) (
   // Clock and reset
   input  wire logic              mclk,
   input  wire logic              reset,
   // Instruction request
   input  wire logic              start,
   input  wire mrls_op_e          op,
   input  wire logic [2:0]        base_register,
   input  wire logic [3:0]        target_register,
   input  wire logic [LIST_W-1:0] reg_list,
   input  wire logic              writeback,
   input  wire logic [9:0]        lit_offset,
   input  wire logic [31:0]       program_counter,
   input  wire logic [31:0]       stack_pointer,
   input  wire logic [3:0]        program_status_flags,
   // Register file read
   output logic [3:0]             rf_raddr,
   input  wire logic [31:0]       rf_rdata,
   // Register file write
   output logic                   rf_we,
   output logic [3:0]             rf_waddr,
   output logic [31:0]            rf_wdata,
   // Memory port
   output logic                   mem_req,
   output logic                   mem_write,
   output logic [31:0]            mem_addr,
   output logic [31:0]            mem_wdata,
   input  wire logic              mem_ack,
   input  wire logic [31:0]       mem_rdata,
   // Results
   output logic                   busy,
   output logic                   done,
   output logic                   branch_valid,
   output logic [31:0]            branch_target,
   output logic                   exec_state_we,
   output logic                   exec_state_bit,
   output logic [3:0]             flags_out
);
   function automatic logic [31:0] words(input logic [LIST_W-1:0] l);
      logic [31:0] c;
      c = 32'h0;
      for (int i = 0; i < LIST_W; i++) begin
         c = c + {31'h0, l[i]};
      end
      return c * `MRLS_WORD_BYTES;
   endfunction : words

   mrls_state_e       state_reg, state_next;
   mrls_op_e          op_reg;
   logic [LIST_W-1:0] list_reg;
   logic [31:0]       addr_reg, fin_reg;
   logic [3:0]        wbreg_reg, cur_reg;
   logic              wb_reg, ispc_reg, busy_reg;
   logic              mem_req_reg, mem_write_reg, rf_we_reg, done_reg, br_reg, xs_we_reg;
   logic [31:0]       mem_addr_reg, mem_wdata_reg, rf_wdata_reg, br_tgt_reg;
   logic [3:0]        rf_waddr_reg, flags_reg;

   wire logic [3:0] pick_idx;
   wire logic       pick_any;
   mrls_pick #(.W(LIST_W)) u_pick (
      .list(list_reg),
      .idx (pick_idx),
      .any (pick_any)
   );

   // Bit eight means link register on push, pc on pop
   wire logic [3:0]  map_reg   = (pick_idx == 4'(`MRLS_EXTRA_BIT)) ?
                                 ((op_reg == MRLS_OP_PUSH) ? `MRLS_REG_LINK : `MRLS_REG_PC) :
                                 pick_idx;
   wire logic        is_store  = (op_reg == MRLS_OP_STORE_MULTIPLE) || (op_reg == MRLS_OP_PUSH);
   wire logic [31:0] base_val  = rf_rdata;
   wire logic [31:0] lit_addr  = {program_counter[31:2], 2'h0} + {22'h0, lit_offset};
   wire logic [31:0] push_low  = stack_pointer - words(reg_list);
   wire logic [31:0] pop_top   = stack_pointer + words(reg_list);
   wire logic [LIST_W-1:0] list_clr = list_reg & ~(LIST_W'(1) << pick_idx);

   assign rf_raddr = (state_reg == MRLS_IDLE) ? {1'b0, base_register} : map_reg;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         MRLS_IDLE: if (start) state_next = MRLS_XFER;
         MRLS_XFER: state_next = MRLS_WAIT;
         MRLS_WAIT: if (mem_ack) state_next = (list_clr == '0 || op_reg == MRLS_OP_LIT) ?
                                              MRLS_DONE : MRLS_XFER;
         MRLS_DONE: state_next = MRLS_IDLE;
         default:   state_next = MRLS_IDLE;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         state_reg <= MRLS_IDLE;
         op_reg <= MRLS_OP_LIT;
         list_reg <= '0;
         addr_reg <= 32'h0;
         fin_reg <= 32'h0;
         wbreg_reg <= 4'h0;
         cur_reg <= 4'h0;
         wb_reg <= 1'b0;
         ispc_reg <= 1'b0;
         busy_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         // Registered copy of the next state keeps busy glitch free
         busy_reg <= (state_next != MRLS_IDLE);
         if (state_reg == MRLS_IDLE && start) begin
            op_reg <= op;
            ispc_reg <= 1'b0;
            // Synonym spellings arrive as the same op code
            case (op)
               MRLS_OP_LIT: begin
                  list_reg <= LIST_W'(1);
                  addr_reg <= lit_addr;
                  wb_reg <= 1'b0;
               end
               MRLS_OP_PUSH: begin
                  list_reg <= reg_list;
                  addr_reg <= push_low;
                  fin_reg <= push_low;
                  wbreg_reg <= `MRLS_REG_SP;
                  wb_reg <= 1'b1;
               end
               MRLS_OP_POP: begin
                  list_reg <= reg_list;
                  addr_reg <= stack_pointer;
                  fin_reg <= pop_top;
                  wbreg_reg <= `MRLS_REG_SP;
                  wb_reg <= 1'b1;
               end
               default: begin
                  list_reg <= reg_list;
                  addr_reg <= base_val;
                  fin_reg <= base_val + words(reg_list);
                  wbreg_reg <= {1'b0, base_register};
                  wb_reg <= writeback;
               end
            endcase
         end else if (state_reg == MRLS_XFER) begin
            cur_reg <= (op_reg == MRLS_OP_LIT) ? target_register : map_reg;
         end else if (state_reg == MRLS_WAIT && mem_ack) begin
            list_reg <= list_clr;
            addr_reg <= addr_reg + `MRLS_WORD_BYTES;
            if (cur_reg == `MRLS_REG_PC && op_reg == MRLS_OP_POP) begin
               ispc_reg <= 1'b1;
               fin_reg <= fin_reg;
            end
         end
      end
   end

   // Output flops
   always_ff @(posedge mclk) begin
      if (reset) begin
         mem_req_reg <= 1'b0;
         mem_write_reg <= 1'b0;
         mem_addr_reg <= 32'h0;
         mem_wdata_reg <= 32'h0;
         rf_we_reg <= 1'b0;
         rf_waddr_reg <= 4'h0;
         rf_wdata_reg <= 32'h0;
         done_reg <= 1'b0;
         br_reg <= 1'b0;
         br_tgt_reg <= 32'h0;
         xs_we_reg <= 1'b0;
         flags_reg <= 4'h0;
      end else begin
         flags_reg <= program_status_flags;
         rf_we_reg <= 1'b0;
         done_reg <= 1'b0;
         br_reg <= 1'b0;
         xs_we_reg <= 1'b0;
         if (state_reg == MRLS_XFER) begin
            // One word per register, one at a time
            mem_req_reg <= 1'b1;
            mem_write_reg <= is_store;
            mem_addr_reg <= addr_reg;
            mem_wdata_reg <= rf_rdata;
         end else if (state_reg == MRLS_WAIT && mem_ack) begin
            mem_req_reg <= 1'b0;
            mem_write_reg <= 1'b0;
            if (!is_store && cur_reg != `MRLS_REG_PC) begin
               rf_we_reg <= 1'b1;
               rf_waddr_reg <= cur_reg;
               rf_wdata_reg <= mem_rdata;
            end
            if (!is_store && cur_reg == `MRLS_REG_PC) begin
               br_tgt_reg <= {mem_rdata[31:1], 1'b0};
               xs_we_reg <= 1'b1;
               mem_wdata_reg <= mem_rdata;
            end
         end else if (state_reg == MRLS_DONE) begin
            // Base update only once every transfer has finished
            rf_we_reg <= wb_reg;
            rf_waddr_reg <= wbreg_reg;
            rf_wdata_reg <= fin_reg;
            br_reg <= ispc_reg;
            done_reg <= 1'b1;
         end
      end
   end

   assign mem_req        = mem_req_reg;
   assign mem_write      = mem_write_reg;
   assign mem_addr       = mem_addr_reg;
   assign mem_wdata      = mem_wdata_reg;
   assign rf_we          = rf_we_reg;
   assign rf_waddr       = rf_waddr_reg;
   assign rf_wdata       = rf_wdata_reg;
   assign done           = done_reg;
   assign branch_valid   = br_reg;
   assign branch_target  = br_tgt_reg;
   assign exec_state_we  = xs_we_reg;
   assign exec_state_bit = mem_wdata_reg[0];
   assign flags_out      = flags_reg;
   assign busy           = busy_reg;

   property p_flags_kept;
      @(posedge mclk) disable iff (reset) 1'b1 |=> flags_out == $past(program_status_flags);
   endproperty
   a_flags_kept: assert property (p_flags_kept) else $error("flags changed");

   // Back-to-back words with a zero-wait memory are three cycles apart
   sequence s_word_pair;
      (state_reg == MRLS_XFER && op_reg != MRLS_OP_LIT) ##3 (state_reg == MRLS_XFER);
   endsequence
   property p_step4;
      @(posedge mclk) disable iff (reset)
         s_word_pair |-> ##1 mem_addr == $past(mem_addr, 3) + `MRLS_WORD_BYTES;
   endproperty
   a_step4: assert property (p_step4) else $error("address step not four");

   property p_wb_late;
      @(posedge mclk) disable iff (reset)
         rf_we && rf_waddr == `MRLS_REG_SP && op_reg == MRLS_OP_PUSH |-> !busy || done;
   endproperty
   a_wb_late: assert property (p_wb_late) else $error("early sp update");

   property p_branch_end;
      @(posedge mclk) disable iff (reset) branch_valid |-> done;
   endproperty
   a_branch_end: assert property (p_branch_end) else $error("branch before end");

   property p_req_one;
      @(posedge mclk) disable iff (reset) state_reg == MRLS_XFER |=> mem_req;
   endproperty
   a_req_one: assert property (p_req_one) else $error("no memory request");

   property p_req_drop;
      @(posedge mclk) disable iff (reset) mem_req && mem_ack |=> !mem_req;
   endproperty
   a_req_drop: assert property (p_req_drop) else $error("request held past ack");
endmodule : mrls_unit
`default_nettype wire

// ### dv/mrls_mem_model.sv
// Word memory model on the far side of the unit's port.
// Assumes requests hold until the cycle after mem_ack.
`timescale 1ns/10ps
`default_nettype none
module mrls_mem_model (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        reset,
   // Request
   input  wire logic        mem_req,
   input  wire logic        mem_write,
   input  wire logic [31:0] mem_addr,
   input  wire logic [31:0] mem_wdata,
   input  wire logic        slow,
   // Answer
   output logic             mem_ack,
   output logic [31:0]      mem_rdata
);
   logic [31:0] mem [logic [31:0]];
   int          wait_cnt = 0;
   initial begin
      mem_ack = 1'b0;
      mem_rdata = 32'h0;
   end
   // Data flips outside the ack cycle so a stale word never matches
   always @(posedge mclk) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (reset)
         wait_cnt <= 0;
      else if (mem_req && !mem_ack) begin
         if (slow && wait_cnt < 3)
            wait_cnt <= wait_cnt + 1;
         else begin
            wait_cnt <= 0;
            mem_ack <= 1'b1;
            if (mem_write)
               mem[mem_addr] = mem_wdata;
            mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : ~mem_addr;
         end
      end
   end
endmodule : mrls_mem_model
`default_nettype wire

// ### dv/multi_register_load_store_bench.sv
// Self-checking bench; the bench itself is the register file.
// Assumes package, defines and memory model compile first.
`timescale 1ns/10ps
`default_nettype none
`include "mrls_defines.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; \
   $display("wrong value at %0t: %h expected %h", $time, (a), (b)); end end
module multi_register_load_store_bench;
   import mrls_pkg::*;
   typedef struct packed {logic wr; logic [3:0] r; logic [31:0] a, d;} mrls_acc_s;
   logic        mclk = 0, reset = 1, start = 0, writeback = 0, slow = 0;
   mrls_op_e    op = MRLS_OP_LIT;
   logic [2:0]  base_register = 0;
   logic [3:0]  target_register = 0, flags = 0, rf_raddr, rf_waddr, flags_out;
   logic [8:0]  reg_list = 9'h001;
   logic [9:0]  lit_offset = 0;
   logic [31:0] pc = 0, rf_wdata, mem_addr, mem_wdata, mem_rdata, branch_target, bt;
   logic        rf_we, mem_req, mem_write, mem_ack, busy, done, branch_valid;
   logic        exec_state_we, exec_state_bit;
   logic        xs_seen = 0;
   logic [31:0] rf [16];
   logic [31:0] ref_mem [logic [31:0]];
   mrls_acc_s   mem_q[$], rfw_q[$], e;
   logic [31:0] br_q[$];
   int          n_errors = 0, compares = 0;
   always #2.5 mclk = ~mclk;
   mrls_unit mrls_unit_i (.mclk, .reset, .start, .op, .base_register, .target_register,
      .reg_list, .writeback, .lit_offset, .program_counter(pc), .stack_pointer(rf[13]),
      .program_status_flags(flags), .rf_raddr, .rf_rdata(rf[rf_raddr]), .rf_we, .rf_waddr,
      .rf_wdata, .mem_req, .mem_write, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .busy,
      .done, .branch_valid, .branch_target, .exec_state_we, .exec_state_bit, .flags_out);
   mrls_mem_model mrls_mem_model_i (.mclk, .reset, .mem_req, .mem_write, .mem_addr,
      .mem_wdata, .slow, .mem_ack, .mem_rdata);
   always @(posedge mclk) begin
      if (!reset && mem_req && mem_ack) begin
         e = mem_q.size() ? mem_q.pop_front() : '1;
         `CHK(mem_write, e.wr)
         `CHK(mem_addr, e.a)
         if (e.wr) `CHK(mem_wdata, e.d)
      end
      if (!reset && rf_we) begin
         e = rfw_q.size() ? rfw_q.pop_front() : '1;
         `CHK(rf_waddr, e.r)
         `CHK(rf_wdata, e.d)
         rf[e.r] = e.d;
      end
      // State bit is written on the pc word, one cycle before the branch
      if (!reset && exec_state_we) begin
         `CHK(exec_state_bit, br_q.size() ? br_q[0][0] : 1'bx)
         xs_seen = 1;
      end
      if (!reset && branch_valid) begin
         bt = br_q.size() ? br_q.pop_front() : '1;
         `CHK(branch_target, bt & ~32'h1)
         `CHK(xs_seen, 1'b1)
         xs_seen = 0;
      end
   end
   task automatic end_sim();
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : end_sim
   task automatic run(mrls_op_e o, logic [2:0] b, logic [8:0] l, logic wb);
      mrls_acc_s acc;
      logic [31:0] a;
      int n;
      n = $countones(l);
      a = (o == MRLS_OP_PUSH) ? rf[13] - 32'(4 * n) : (o == MRLS_OP_POP) ? rf[13] : rf[b];
      if (o == MRLS_OP_LIT)
         a = {pc[31:2], 2'b00} + 32'(lit_offset);
      for (int i = 0; i < 9; i++) begin
         if (l[i]) begin
            acc.r = (o == MRLS_OP_LIT) ? target_register : (i < 8) ? 4'(i) :
                    (o == MRLS_OP_PUSH) ? `MRLS_REG_LINK : `MRLS_REG_PC;
            acc.wr = (o == MRLS_OP_STORE_MULTIPLE) || (o == MRLS_OP_PUSH);
            acc.a = a;
            acc.d = acc.wr ? rf[acc.r] : ref_mem.exists(a) ? ref_mem[a] : ~a;
            if (acc.wr)
               ref_mem[a] = acc.d;
            else if (acc.r == `MRLS_REG_PC)
               br_q.push_back(acc.d);
            else
               rfw_q.push_back(acc);
            mem_q.push_back(acc);
            a += 4;
         end
      end
      acc.r = (o == MRLS_OP_PUSH || o == MRLS_OP_POP) ? `MRLS_REG_SP : {1'b0, b};
      acc.d = (o == MRLS_OP_PUSH) ? rf[13] - 32'(4 * n) : rf[acc.r] + 32'(4 * n);
      if (o != MRLS_OP_LIT && (wb || o == MRLS_OP_PUSH || o == MRLS_OP_POP))
         rfw_q.push_back(acc);
      @(posedge mclk) #1;
      {start, op, base_register, reg_list, writeback} = {1'b1, o, b, l, wb};
      flags = 4'($urandom);
      @(posedge mclk) #1 start = 0;
      `CHK(busy, 1'b1)
      // Second request lands while busy and must be ignored
      repeat (2) @(posedge mclk);
      #1 start = 1;
      @(posedge mclk) #1 start = 0;
      for (int k = 0; k <= 300; k++) begin
         @(posedge mclk);
         if (done === 1'b1)
            break;
         if (k == 300) begin
            n_errors++;
            end_sim();
         end
      end
      #1;
      `CHK(flags_out, flags)
      `CHK(busy, 1'b0)
      `CHK(mem_q.size() + rfw_q.size() + br_q.size(), 0)
      $display("test op %0d ended at %0t", o, $time);
   endtask : run
   initial begin
      mrls_op_e o;
      logic [2:0] b;
      logic [8:0] l;
      void'($urandom(71201));
      for (int i = 0; i < 16; i++)
         rf[i] = 32'h1000 + 32'(i * 64);
      rf[13] = 32'h3000;
      rf[14] = 32'h2461;
      repeat (12) @(posedge mclk);
      #1 reset = 0;
      pc = 32'h1002;
      lit_offset = 10'h3fc;
      target_register = 4'h3;
      run(MRLS_OP_LIT, 3'h0, 9'h001, 1'b0);
      run(MRLS_OP_STORE_MULTIPLE, 3'h1, 9'h01e, 1'b1);
      run(MRLS_OP_LOAD_MULTIPLE, 3'h1, 9'h013, 1'b0);
      slow = 1;
      run(MRLS_OP_PUSH, 3'h0, 9'h124, 1'b0);
      run(MRLS_OP_POP, 3'h0, 9'h124, 1'b0);
      for (int t = 0; t < 40; t++) begin
         b = 3'($urandom_range(7));
         l = 9'($urandom_range(255, 1));
         o = $urandom_range(1) ? MRLS_OP_STORE_MULTIPLE : MRLS_OP_LOAD_MULTIPLE;
         slow = 1'($urandom);
         if (o == MRLS_OP_STORE_MULTIPLE && l[b] && (l & ((9'h1 << b) - 9'h1)) != 0)
            l[b] = 0;
         rf[b] = 32'h1000 + 32'($urandom_range(1023) * 4);
         run(o, b, l, !(o == MRLS_OP_LOAD_MULTIPLE && l[b]));
         lit_offset = 10'($urandom_range(255) * 4);
         target_register = 4'($urandom_range(7));
         run(MRLS_OP_LIT, 3'h0, 9'h001, 1'b0);
      end
      end_sim();
   end
endmodule : multi_register_load_store_bench
`default_nettype wire
